/* design/ttr_replica.sv */
// Thermal replica: used thermal capacity, recomputed every 5 ms.
// Assumes currents and sensor reading come from logic on clk.
`timescale 1ns/1ns
module ttr_replica
  import ttr_pkg::*;
#(
  parameter int CYCLE_CLKS = CYCLE_CLKS_DEF,
  parameter int N_PTS = CURVE_N
)(
  // Clock and reset
  input logic clk,
  input logic reset_n,
  // Measurements
  input ttr_cur_t phase_rms [3],
  input logic signed [15:0] sensor_temp,
  // Settings
  input ttr_th_cfg_t th_cfg,
  input ttr_amb_cfg_t amb_cfg,
  input ttr_pt_t curve [N_PTS],
  input logic restart,
  // Results
  output logic [31:0] theta_reg,
  output logic [15:0] amb_factor_reg,
  output logic [15:0] max_current_reg,
  output logic heating_reg,
  output logic cycle_pulse_reg,
  output logic update_pulse_reg
);

  localparam int NW = 48;
  localparam int DW = 32;
  localparam int PW = $clog2(N_PTS + 1);

  if (CYCLE_CLKS < MIN_CYCLE_CLKS || N_PTS < 3)
  begin : g_bad_param
    $error("ttr_replica: cycle too short or too few points");
  end

  // ****************
  // Cycle timer
  // ****************
  logic [31:0] cyc_cnt_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc_cnt_reg <= '0;
      cycle_pulse_reg <= 1'b0;
    end
    else
    begin
      cycle_pulse_reg <= cyc_cnt_reg == 32'(CYCLE_CLKS - 1);
      if (cyc_cnt_reg == 32'(CYCLE_CLKS - 1))
        cyc_cnt_reg <= '0;
      else
        cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
    end
  end

  // ****************
  // Serial divider
  // ****************
  // One shared restoring divider keeps the area small; a cycle needs
  // about two hundred clocks, far below the 5 ms budget.
  logic [NW-1:0] dv_num;
  logic [NW-1:0] dv_quo_reg;
  logic [DW-1:0] dv_den;
  logic [DW-1:0] dv_den_reg;
  logic [DW-1:0] dv_rem_reg;
  logic [5:0] dv_cnt_reg;
  logic dv_load;
  logic dv_done;
  logic [DW:0] dv_sh;

  assign dv_sh = {dv_rem_reg, dv_quo_reg[NW-1]};
  assign dv_done = dv_cnt_reg == '0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dv_quo_reg <= '0;
      dv_rem_reg <= '0;
      dv_den_reg <= '0;
      dv_cnt_reg <= '0;
    end
    else if (dv_load)
    begin
      dv_quo_reg <= dv_num;
      dv_rem_reg <= '0;
      dv_den_reg <= dv_den;
      dv_cnt_reg <= 6'(NW);
    end
    else if (!dv_done)
    begin
      if (dv_sh >= {1'b0, dv_den_reg})
      begin
        dv_rem_reg <= DW'(dv_sh - {1'b0, dv_den_reg});
        dv_quo_reg <= {dv_quo_reg[NW-2:0], 1'b1};
      end
      else
      begin
        dv_rem_reg <= dv_sh[DW-1:0];
        dv_quo_reg <= {dv_quo_reg[NW-2:0], 1'b0};
      end
      dv_cnt_reg <= dv_cnt_reg - 6'h1;
    end
  end

  // ****************
  // Datapath terms
  // ****************
  ttr_state_t st_reg;
  logic signed [15:0] sens_reg;
  logic signed [15:0] amb_t_reg;
  ttr_pt_t seg_a_reg;
  ttr_pt_t seg_b_reg;
  logic [31:0] x2_reg;
  logic [31:0] alpha_reg;
  logic init_reg;
  logic [15:0] imax;
  ttr_pt_t pts [N_PTS];
  logic [PW-1:0] npts;
  logic [PW-1:0] idx;
  ttr_pt_t pa;
  ttr_pt_t pb;
  logic conv_f;
  logic signed [21:0] f_num;
  logic signed [16:0] seg_den;
  logic signed [16:0] seg_td;
  logic [15:0] k_mag;
  logic [47:0] d_prod;
  logic [15:0] x_sat;
  logic heats;
  logic [12:0] tau_sel;
  logic [31:0] diff_mag;
  logic [31:0] step;

  always_comb
  begin
    imax = phase_rms[0];
    for (int i = 1; i < 3; i++)
      if (phase_rms[i] > imax)
        imax = phase_rms[i];
  end

  // Linear mode is a three-point curve through the reference point
  always_comb
  begin
    pts = curve;
    npts = PW'(N_PTS);
    if (!amb_cfg.use_curve)
    begin
      pts[0] = '{amb_cfg.low_temp_limit, amb_cfg.k_low};
      pts[1] = '{amb_cfg.reference_temperature, K_ONE};
      pts[2] = '{amb_cfg.high_temp_limit, amb_cfg.k_high};
      npts = PW'(3);
    end
  end

  // Curve points must be in rising temperature order
  always_comb
  begin
    idx = '0;
    for (int i = 0; i < N_PTS; i++)
      if (PW'(i) < npts && amb_t_reg >= pts[i].t)
        idx = PW'(i + 1);
  end

  assign pa = pts[(idx == '0) ? '0 : idx - PW'(1)];
  assign pb = pts[(idx >= npts) ? npts - PW'(1) : idx];
  assign seg_den = {pb.t[15], pb.t} - {pa.t[15], pa.t};
  assign seg_td = {amb_t_reg[15], amb_t_reg} - {pa.t[15], pa.t};
  assign k_mag = (pb.k >= pa.k) ? pb.k - pa.k : pa.k - pb.k;
  assign conv_f = amb_cfg.use_sensor && amb_cfg.unit_f;
  assign f_num = 22'(sens_reg) * F_MUL + F_OFS;
  assign d_prod = 48'(th_cfg.cap_current) * 48'(th_cfg.service_factor)
                  * 48'(amb_factor_reg);
  assign x_sat = (dv_quo_reg[NW-1:16] != '0) ? 16'hFFFF : dv_quo_reg[15:0];
  assign heats = x2_reg > theta_reg;
  assign tau_sel = heats ? th_cfg.tau_heat : th_cfg.tau_cool;
  // A restart between direction choice and apply must not wrap the step
  assign diff_mag = heating_reg
                    ? ((x2_reg > theta_reg) ? x2_reg - theta_reg : '0)
                    : ((theta_reg > x2_reg) ? theta_reg - x2_reg : '0);
  assign step = 32'((64'(diff_mag) * 64'(alpha_reg)) >> TH_FRAC);

  always_comb
  begin
    dv_load = 1'b0;
    dv_num = '0;
    dv_den = '0;
    unique case (st_reg)
      ST_TEMP:
      begin
        dv_load = conv_f;
        dv_num = NW'(f_num[21] ? -f_num : f_num);
        dv_den = F_DIV;
      end
      ST_SEG:
      begin
        dv_load = idx != '0 && idx < npts && seg_den > 0;
        dv_num = NW'(33'(k_mag) * 33'(seg_td[15:0]));
        dv_den = DW'(seg_den[15:0]);
      end
      ST_X:
      begin
        dv_load = 1'b1;
        dv_num = NW'({imax_hold(max_current_reg), {FRAC_W{1'b0}}});
        dv_den = DW'(d_prod >> TH_FRAC);
      end
      ST_ALPHA:
      begin
        dv_load = 1'b1;
        dv_num = NW'(THETA_ONE);
        dv_den = DW'(ALPHA_K) * DW'(tau_sel);
      end
      ST_IDLE, ST_TEMP_W, ST_SEG_W, ST_X_W, ST_ALPHA_W, ST_APPLY:
      begin
        dv_load = 1'b0;
      end
    endcase
  end

  function automatic logic [15:0] imax_hold(input logic [15:0] v);
    imax_hold = v;
  endfunction : imax_hold

  // ****************
  // Sequencer
  // ****************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= ST_IDLE;
      max_current_reg <= '0;
      sens_reg <= '0;
      amb_t_reg <= '0;
      seg_a_reg <= '0;
      seg_b_reg <= '0;
      amb_factor_reg <= K_ONE;
      x2_reg <= '0;
      alpha_reg <= '0;
      heating_reg <= 1'b0;
    end
    else
    begin
      unique case (st_reg)
        ST_IDLE:
          if (cycle_pulse_reg)
          begin
            max_current_reg <= imax;
            sens_reg <= sensor_temp;
            st_reg <= ST_TEMP;
          end
        ST_TEMP:
          if (conv_f)
            st_reg <= ST_TEMP_W;
          else
          begin
            amb_t_reg <= amb_cfg.use_sensor ? sens_reg
                                            : amb_cfg.manual_t;
            st_reg <= ST_SEG;
          end
        ST_TEMP_W:
          if (dv_done)
          begin
            amb_t_reg <= f_num[21] ? -16'(dv_quo_reg) : 16'(dv_quo_reg);
            st_reg <= ST_SEG;
          end
        ST_SEG:
        begin
          seg_a_reg <= pa;
          seg_b_reg <= pb;
          if (dv_load)
            st_reg <= ST_SEG_W;
          else
          begin
            amb_factor_reg <= pb.k;
            st_reg <= ST_X;
          end
        end
        ST_SEG_W:
          if (dv_done)
          begin
            amb_factor_reg <= (seg_b_reg.k >= seg_a_reg.k)
                              ? seg_a_reg.k + dv_quo_reg[15:0]
                              : seg_a_reg.k - dv_quo_reg[15:0];
            st_reg <= ST_X;
          end
        ST_X:
          st_reg <= ST_X_W;
        ST_X_W:
          if (dv_done)
          begin
            x2_reg <= 32'(x_sat) * 32'(x_sat);
            st_reg <= ST_ALPHA;
          end
        ST_ALPHA:
        begin
          heating_reg <= heats;
          st_reg <= ST_ALPHA_W;
        end
        ST_ALPHA_W:
          if (dv_done)
          begin
            // A zero time constant divides to all ones: step at once
            alpha_reg <= (dv_quo_reg > NW'(THETA_ONE)) ? THETA_ONE
                                                      : dv_quo_reg[31:0];
            st_reg <= ST_APPLY;
          end
        ST_APPLY:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************
  // Thermal state
  // ****************
  // The cold value is a setting, so reset loads a constant and the
  // setting is taken at the first edge after release.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      theta_reg <= COLD_DEF;
      init_reg <= 1'b1;
      update_pulse_reg <= 1'b0;
    end
    else
    begin
      init_reg <= 1'b0;
      update_pulse_reg <= st_reg == ST_APPLY;
      if (restart || init_reg)
        theta_reg <= th_cfg.cold_theta;
      else if (st_reg == ST_APPLY)
        theta_reg <= heating_reg ? theta_reg + step
                                 : theta_reg - step;
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_start;
    st_reg == ST_IDLE && cycle_pulse_reg ##1 st_reg == ST_TEMP;
  endsequence

  property p_cycle_update;
    s_start |-> ##[1:400] update_pulse_reg;
  endproperty
  a_cycle_update: assert property (p_cycle_update)
    else $error("cycle produced no update");

  property p_max_cur;
    st_reg == ST_IDLE && cycle_pulse_reg |=>
      max_current_reg >= $past(phase_rms[0]) &&
      max_current_reg >= $past(phase_rms[1]) &&
      max_current_reg >= $past(phase_rms[2]);
  endproperty
  a_max_cur: assert property (p_max_cur)
    else $error("current input is not the phase maximum");

  property p_manual_amb;
    st_reg == ST_TEMP && !amb_cfg.use_sensor |=>
      amb_t_reg == $past(amb_cfg.manual_t);
  endproperty
  a_manual_amb: assert property (p_manual_amb)
    else $error("manual ambient not used");

  property p_low_hold;
    st_reg == ST_SEG && idx == '0 |=> amb_factor_reg == $past(pts[0].k);
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("factor not held below lowest point");

  property p_interp;
    st_reg == ST_SEG_W && dv_done |=>
      (amb_factor_reg >= seg_a_reg.k && amb_factor_reg <= seg_b_reg.k) ||
      (amb_factor_reg <= seg_a_reg.k && amb_factor_reg >= seg_b_reg.k);
  endproperty
  a_interp: assert property (p_interp)
    else $error("interpolated factor outside segment");

  property p_tau_sel;
    st_reg == ST_ALPHA |=> heating_reg == ($past(x2_reg) > $past(theta_reg));
  endproperty
  a_tau_sel: assert property (p_tau_sel)
    else $error("heating or cooling choice wrong");

  property p_heat;
    st_reg == ST_APPLY && heating_reg && !restart && !init_reg |=>
      theta_reg <= $past(x2_reg) && theta_reg >= $past(theta_reg);
  endproperty
  a_heat: assert property (p_heat)
    else $error("heating overshot its target");

  property p_cool;
    st_reg == ST_APPLY && !heating_reg && !restart && !init_reg |=>
      theta_reg >= $past(x2_reg) && theta_reg <= $past(theta_reg);
  endproperty
  a_cool: assert property (p_cool)
    else $error("cooling overshot its target");

  property p_restart;
    restart |=> theta_reg == $past(th_cfg.cold_theta);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not load cold value");

  property p_hold;
    $changed(theta_reg) |->
      $past(st_reg == ST_APPLY || restart || init_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state changed between updates");

endmodule : ttr_replica

/* design/ttr_pkg.sv */
// Constants and carrier types for the transformer thermal replica.
// Assumes a 250 MHz processing clock and fixed-point settings.
package ttr_pkg;

  // ****************
  // Timing
  // ****************
  localparam int CLK_NS = 4;
  localparam int CYCLE_MS = 5;
  localparam int CYCLE_CLKS_DEF = CYCLE_MS * 1000000 / CLK_NS;
  localparam int MIN_CYCLE_CLKS = 400;
  // Time constants are set in 0.1 min steps
  localparam int TAU_STEP_MS = 6000;
  localparam int ALPHA_K = TAU_STEP_MS / CYCLE_MS;

  // ****************
  // Fixed point
  // ****************
  localparam int FRAC_W = 12;
  localparam int TH_FRAC = 24;
  localparam logic [15:0] K_ONE = 16'h1000;
  localparam logic [31:0] THETA_ONE = 32'h0100_0000;
  localparam logic [31:0] COLD_DEF = 32'h0099_999A;
  localparam int CURVE_N = 10;
  // Tenths of Celsius to tenths of Fahrenheit: (c*18+3200)/10
  localparam logic signed [21:0] F_MUL = 22'sh12;
  localparam logic signed [21:0] F_OFS = 22'shC80;
  localparam logic [31:0] F_DIV = 32'h0000_000A;

  // ****************
  // Carriers
  // ****************
  typedef logic [15:0] ttr_cur_t;

  typedef struct packed {
    logic signed [15:0] t;
    logic [15:0] k;
  } ttr_pt_t;

  typedef struct packed {
    logic [15:0] cap_current;
    logic [15:0] service_factor;
    logic [12:0] tau_heat;
    logic [12:0] tau_cool;
    logic [31:0] cold_theta;
  } ttr_th_cfg_t;

  typedef struct packed {
    logic use_sensor;
    logic unit_f;
    logic use_curve;
    logic signed [15:0] manual_t;
    logic signed [15:0] low_temp_limit;
    logic signed [15:0] reference_temperature;
    logic signed [15:0] high_temp_limit;
    logic [15:0] k_low;
    logic [15:0] k_high;
  } ttr_amb_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TEMP, ST_TEMP_W, ST_SEG, ST_SEG_W,
    ST_X, ST_X_W, ST_ALPHA, ST_ALPHA_W, ST_APPLY
  } ttr_state_t;

endpackage : ttr_pkg

/* test/ttr_front.sv */
// Front end model: phase true-RMS magnitudes and the ambient sensor.
// Assumes the bench names the next measurement; it shows one edge later.
`timescale 1ns/1ns
module ttr_front
  import ttr_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic reset_n,
  // Next measurement set
  input ttr_cur_t cur_req [3],
  input logic signed [15:0] temp_req,
  // Towards the replica
  output ttr_cur_t phase_rms [3],
  output logic signed [15:0] sensor_temp
);
  // Magnitudes already hold the harmonics up to the 31st
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_rms <= '{default: 16'h0000};
      sensor_temp <= 16'sh0000;
    end
    else
    begin
      phase_rms <= cur_req;
      sensor_temp <= temp_req;
    end
  end
endmodule : ttr_front

/* test/transformer_thermal_replica_bench.sv */
// Self-checking bench for the thermal replica, random settings per cycle.
// Assumes ttr_pkg and the front end model; cycle shortened to 500 clocks.
`timescale 1ns/1ns
module transformer_thermal_replica_bench
  import ttr_pkg::*;
;
  // ****************
  // Stimulus and design
  // ****************
  localparam int CYC = 500;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic restart;
  logic [31:0] seed = 32'h0000_ED06;
  ttr_cur_t cur_req [3];
  ttr_cur_t phase_rms [3];
  logic signed [15:0] temp_req;
  logic signed [15:0] sensor_temp;
  ttr_th_cfg_t th_cfg;
  ttr_amb_cfg_t amb_cfg;
  ttr_pt_t curve [CURVE_N];
  logic [31:0] theta_reg;
  logic [15:0] amb_factor_reg;
  logic [15:0] max_current_reg;
  logic heating_reg;
  logic cycle_pulse_reg;
  logic update_pulse_reg;
  ttr_cur_t mx_exp;
  time last_pulse = 0;
  real th_prev, th_new, x2_exp, tol_exp;
  bit heat_exp;
  int n_mismatch = 0;
  int checked = 0;

  always #2 clk = ~clk;

  ttr_front front_u (
    .clk(clk), .reset_n(reset_n), .cur_req(cur_req), .temp_req(temp_req),
    .phase_rms(phase_rms), .sensor_temp(sensor_temp));

  ttr_replica #(.CYCLE_CLKS(CYC), .N_PTS(CURVE_N)) dut_u (
    .clk(clk), .reset_n(reset_n), .phase_rms(phase_rms),
    .sensor_temp(sensor_temp), .th_cfg(th_cfg), .amb_cfg(amb_cfg),
    .curve(curve), .restart(restart), .theta_reg(theta_reg),
    .amb_factor_reg(amb_factor_reg), .max_current_reg(max_current_reg),
    .heating_reg(heating_reg), .cycle_pulse_reg(cycle_pulse_reg),
    .update_pulse_reg(update_pulse_reg));

  // ****************
  // Expectations
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic real abs_r(real v);
    return v < 0.0 ? -v : v;
  endfunction : abs_r

  function automatic real lin(int t, int t0, int t1, real k0, real k1);
    return k0 + (k1 - k0) * (t - t0) / (t1 - t0);
  endfunction : lin

  function automatic real exp_k();
    int t;
    t = amb_cfg.manual_t;
    if (amb_cfg.use_sensor)
      t = amb_cfg.unit_f ? (int'(sensor_temp) * 18 + 3200) / 10 : sensor_temp;
    if (amb_cfg.use_curve)
    begin
      if (t <= curve[0].t)
        return curve[0].k / 4096.0;
      for (int j = 1; j < CURVE_N; j++)
        if (t <= curve[j].t)
          return lin(t, curve[j - 1].t, curve[j].t, curve[j - 1].k / 4096.0,
            curve[j].k / 4096.0);
      return curve[CURVE_N - 1].k / 4096.0;
    end
    if (t <= amb_cfg.low_temp_limit)
      return amb_cfg.k_low / 4096.0;
    if (t >= amb_cfg.high_temp_limit)
      return amb_cfg.k_high / 4096.0;
    if (t <= amb_cfg.reference_temperature)
      return lin(t, amb_cfg.low_temp_limit, amb_cfg.reference_temperature,
        amb_cfg.k_low / 4096.0, 1.0);
    return lin(t, amb_cfg.reference_temperature, amb_cfg.high_temp_limit,
      1.0, amb_cfg.k_high / 4096.0);
  endfunction : exp_k

  // Tolerance widens with the load ratio: X is quantised before squaring
  function automatic real exp_theta(real k);
    real x, frac;
    int tau;
    x = mx_exp * 4096.0 / (1.0 * th_cfg.cap_current * th_cfg.service_factor * k);
    if (x > 65535.0 / 4096.0)
      x = 65535.0 / 4096.0;
    x2_exp = x * x;
    heat_exp = x2_exp > th_prev;
    tau = heat_exp ? th_cfg.tau_heat : th_cfg.tau_cool;
    frac = tau == 0 ? 1.0 : 1.0 / (1200.0 * tau);
    tol_exp = frac * (3.0e-3 * x2_exp + 2.0e-3) + 4.0e-6;
    return th_prev + (x2_exp - th_prev) * frac;
  endfunction : exp_theta

  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic run_cycle(output bit amb_ok);
    logic [31:0] prev_bits;
    real k, e;
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (cycle_pulse_reg !== 1'b1 && n < 2 * CYC)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (last_pulse != 0) chk($time - last_pulse == CYC * CLK_NS, "period");
    last_pulse = $time;
    prev_bits = theta_reg;
    th_prev = prev_bits / 2.0 ** 24;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (!update_pulse_reg) chk(theta_reg === prev_bits, "early move");
    end
    while (update_pulse_reg !== 1'b1 && n < 300);
    chk(update_pulse_reg === 1'b1, "no update");
    k = exp_k();
    amb_ok = !$isunknown(amb_factor_reg) &&
      abs_r(amb_factor_reg - k * 4096.0) <= 4.0;
    th_new = theta_reg / 2.0 ** 24;
    e = exp_theta(k);
    chk(max_current_reg === mx_exp, "max current");
    chk(!$isunknown(theta_reg) && abs_r(th_new - e) <= tol_exp, "step");
    if (abs_r(x2_exp - th_prev) > 1.0e-2) chk(heating_reg === heat_exp, "tau");
  endtask : run_cycle

  // ****************
  // Sequence
  // ****************
  initial
  begin
    #(CYC * CLK_NS * 80);
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    int mode;
    bit zero;
    bit amb_ok;
    ttr_cur_t c;
    logic [31:0] cold;
    restart = 1'b0;
    cur_req = '{default: 16'h0000};
    temp_req = 16'sh0000;
    th_cfg = '{16'h1000, 16'h1000, 13'h0001, 13'h0002, 32'h00C0_0000};
    amb_cfg = '{1'b0, 1'b0, 1'b0, 16'sh00C8, 16'shFF38, 16'sh00C8,
      16'sh0190, 16'h1400, 16'h0C00};
    for (int j = 0; j < CURVE_N; j++)
      curve[j] = '{16'(j * 16'h0064) - 16'sh00C8, 16'h0C00 + 16'(j * 16'h0050)};
    repeat (16) @(posedge clk);
    #1;
    chk(theta_reg === COLD_DEF, "reset state");
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(theta_reg === th_cfg.cold_theta, "start state");
    for (int i = 0; i < 30; i++)
    begin
      mode = i % 6;
      zero = i % 4 == 3;
      mx_exp = 16'h0000;
      @(posedge clk);
      amb_cfg.use_sensor <= mode == 3 || mode == 4;
      amb_cfg.unit_f <= mode == 4;
      amb_cfg.use_curve <= mode == 5;
      amb_cfg.manual_t <= mode == 0 ? 16'shFE0C : mode == 1 ? 16'sh01F4 :
        16'(rnd() % 32'h0000_044C) - 16'sh012C;
      temp_req <= 16'(rnd() % 32'h0000_0320) - 16'sh0190;
      th_cfg.service_factor <= 16'h0C00 + 16'(rnd() % 32'h0000_0800);
      th_cfg.tau_heat <= i % 5 == 0 ? 13'h0000 : 13'(rnd() % 32'h8) + 13'h1;
      th_cfg.tau_cool <= 13'(rnd() % 32'h0000_0008) + 13'h0001;
      for (int p = 0; p < 3; p++)
      begin
        c = zero ? 16'h0000 : 16'(rnd() % 32'h0000_1800);
        cur_req[p] <= c;
        if (c > mx_exp)
          mx_exp = c;
      end
      if (i % 4 == 1)
      begin
        cold = rnd() % 32'h0180_0000;
        restart <= 1'b1;
        th_cfg.cold_theta <= cold;
        @(posedge clk);
        restart <= 1'b0;
        #1;
        chk(theta_reg === cold, "restart");
      end
      run_cycle(amb_ok);
      case (mode)
        0, 1: chk(amb_ok, "clamped factor");
        2: chk(amb_ok, "linear factor");
        3: chk(amb_ok, "sensor factor");
        4: chk(amb_ok, "factor in F");
        default: chk(amb_ok, "curve factor");
      endcase
      if (zero && th_prev > 0.0) chk(th_new < th_prev, "decay");
    end
    // Full nominal load with instant steps must settle at 100% or less than 4096 LSBs below it
    @(posedge clk);
    amb_cfg.use_sensor <= 1'b0;
    amb_cfg.use_curve <= 1'b0;
    amb_cfg.manual_t <= 16'sh00C8;
    th_cfg.service_factor <= 16'h1000;
    th_cfg.tau_heat <= 13'h0000;
    th_cfg.tau_cool <= 13'h0000;
    cur_req <= '{default: 16'h1000};
    mx_exp = 16'h1000;
    repeat (2)
    begin
      run_cycle(amb_ok);
      chk(theta_reg <= THETA_ONE && theta_reg > THETA_ONE - 32'h0000_1000, "full");
    end
    complete_run();
  end
endmodule : transformer_thermal_replica_bench
